// ---- core/batt_hist.sv ----
`include "batt_hist_regs.svh"
module batt_hist
    import batt_hist_pkg::*;
#(
    parameter int unsigned HALF_MIN_CYCLES = `HALF_MIN_CYCLES,
    parameter int unsigned NV_COPY_CYCLES  = `NV_COPY_CYCLES,
    parameter logic [15:0] IDENT_VALUE     = `IDENT_VALUE   // Arbitrary value
) (
    input  wire logic       sys_clk,     // 50 MHz clock
    input  wire logic       nrst,        // Async reset, active low
    input  wire reg_req_t   req,         // Register access
    input  wire cmd_t       cmd,         // Command events
    input  wire logic       page_lock,   // First user page locked
    input  wire logic       conv_done,   // Sensor result ready
    input  wire logic [7:0] conv_temp,   // Sensor result
    output logic      [7:0] rd_data_q,   // Read data
    output logic            conv_start_q,// Sensor start pulse
    output logic            count_hold_q // Counting frozen
);
    logic [31:0]     half_cnt_q;
    logic            half_tick;
    logic [6:0]      halves_q;
    logic [6:0]      interval_halves;
    logic            minute_half_q;
    logic [23:0]     elapsed_q;
    logic [2:0]      interval_q;
    logic [7:0]      limit_q [7];
    logic [7:0]      temp_q;
    logic            lock_q;
    logic            lock_s1_q;
    logic            done_s1_q;
    logic            done_s2_q;
    logic            done_s3_q;
    logic            done_rise;
    logic [7:0]      ctemp_s1_q;
    logic [7:0]      ctemp_s2_q;
    conv_state_t     conv_q;
    logic            sample_due_q;
    logic [31:0]     nv_cnt_q;
    logic            nv_busy_q;
    logic [15:0]     cycle_q;
    logic [2:0]      bin_idx;
    logic [2:0]      bin_idx_past;
    logic [7:0]      bin_inc;
    logic [15:0]     bin_val [8];
    logic [7:0]      status_byte;
    logic [7:0]      rd_d;
    logic [3:0]      bin_off;
    logic [2:0]      lim_off;

    // Sensor and lock level cross in through two flip-flops
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            lock_s1_q  <= 1'b0;
            lock_q     <= 1'b0;
            done_s1_q  <= 1'b0;
            done_s2_q  <= 1'b0;
            done_s3_q  <= 1'b0;
            ctemp_s1_q <= 8'h00;
            ctemp_s2_q <= 8'h00;
        end else begin
            lock_s1_q  <= page_lock;
            lock_q     <= lock_s1_q;
            done_s1_q  <= conv_done;
            done_s2_q  <= done_s1_q;
            done_s3_q  <= done_s2_q;
            ctemp_s1_q <= conv_temp;
            ctemp_s2_q <= ctemp_s1_q;
        end
    end
    assign done_rise = done_s2_q && !done_s3_q;

    // Freeze counting from any command until bus reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_hold_q <= 1'b0;
        end else if (cmd.start) begin
            count_hold_q <= 1'b1;
        end else if (cmd.bus_reset) begin
            count_hold_q <= 1'b0;
        end
    end

    // Half-minute timebase, free running
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            half_cnt_q <= 32'h0000_0000;
        end else if (half_cnt_q == HALF_MIN_CYCLES - 1) begin
            half_cnt_q <= 32'h0000_0000;
        end else begin
            half_cnt_q <= half_cnt_q + 32'h0000_0001;
        end
    end
    assign half_tick = (half_cnt_q == HALF_MIN_CYCLES - 1);

    // Sampling period in half minutes
    always_comb begin
        case (interval_q)
            3'h0:    interval_halves = 7'd1;
            3'h1:    interval_halves = 7'd2;
            3'h2:    interval_halves = 7'd4;
            3'h3:    interval_halves = 7'd8;
            3'h4:    interval_halves = 7'd15;
            3'h5:    interval_halves = 7'd30;
            3'h6:    interval_halves = 7'd60;
            3'h7:    interval_halves = 7'd120;
            default: interval_halves = 7'd2;
        endcase
    end

    // Elapsed minutes, counted only while not frozen
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            minute_half_q <= 1'b0;
            elapsed_q     <= 24'h000000;
        end else if (half_tick && !count_hold_q) begin
            minute_half_q <= !minute_half_q;
            if (minute_half_q) begin
                elapsed_q <= elapsed_q + 24'h000001;
            end
        end
    end

    // Sample interval counter; raises a sample request each period
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            halves_q     <= 7'd0;
            sample_due_q <= 1'b0;
        end else begin
            if (half_tick && !count_hold_q) begin
                if (halves_q + 7'd1 >= interval_halves) begin
                    halves_q     <= 7'd0;
                    sample_due_q <= 1'b1;
                end else begin
                    halves_q <= halves_q + 7'd1;
                end
            end else if (conv_q == CONV_IDLE && !cmd.convert && !count_hold_q) begin
                sample_due_q <= 1'b0;
            end
        end
    end

    // Conversion control; on-demand requests use the same timing
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            conv_q       <= CONV_IDLE;
            conv_start_q <= 1'b0;
            temp_q       <= `RST_TEMP;
        end else begin
            conv_start_q <= 1'b0;
            case (conv_q)
                CONV_IDLE: begin
                    if (cmd.convert) begin
                        conv_q       <= CONV_DEMAND;
                        conv_start_q <= 1'b1;
                    end else if (sample_due_q && !count_hold_q) begin
                        conv_q       <= CONV_PERIODIC;
                        conv_start_q <= 1'b1;
                    end
                end
                CONV_PERIODIC, CONV_DEMAND: begin
                    if (done_rise) begin
                        temp_q <= ctemp_s2_q;
                        conv_q <= CONV_IDLE;
                    end
                end
                default: conv_q <= CONV_IDLE;
            endcase
        end
    end

    // Bin selection: count limits at or below the sample
    always_comb begin
        bin_idx = 3'd0;
        for (int i = 0; i < 7; i++) begin
            if ($signed(ctemp_s2_q) >= $signed(limit_q[i])) begin
                bin_idx = bin_idx + 3'd1;
            end
        end
    end

    // Credit the bin only for a periodic result while not frozen
    always_comb begin
        bin_inc = 8'h00;
        if (conv_q == CONV_PERIODIC && done_rise && !count_hold_q) begin
            bin_inc[bin_idx] = 1'b1;
        end
    end

    // Eight bin accumulators
    for (genvar g = 0; g < 8; g++) begin : g_bin
        bin_accum u_acc (
            .sys_clk (sys_clk),
            .nrst    (nrst),
            .inc     (bin_inc[g]),
            .count_q (bin_val[g])
        );
    end

    // Nonvolatile copy busy timer
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            nv_busy_q <= 1'b0;
            nv_cnt_q  <= 32'h0000_0000;
        end else if (cmd.nv_copy && !nv_busy_q) begin
            nv_busy_q <= 1'b1;
            nv_cnt_q  <= 32'h0000_0000;
        end else if (nv_busy_q) begin
            if (nv_cnt_q == NV_COPY_CYCLES - 1) begin
                nv_busy_q <= 1'b0;
            end else begin
                nv_cnt_q <= nv_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Charge cycle counter; clear has priority
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cycle_q <= 16'h0000;
        end else if (cmd.clr_cycle) begin
            cycle_q <= 16'h0000;
        end else if (cmd.inc_cycle) begin
            cycle_q <= cycle_q + 16'h0001;
        end
    end

    // Writable limits and interval
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            interval_q <= `RST_INTERVAL;
            for (int i = 0; i < 7; i++) begin
                limit_q[i] <= `RST_LIMIT0 + 8'(i) * `RST_LIMIT_STEP;
            end
        end else if (req.wr) begin
            if (req.addr == `ADDR_INTERVAL) begin
                interval_q <= req.wdata[2:0];
            end
            if (req.addr >= `ADDR_LIMIT_FIRST && req.addr <= `ADDR_LIMIT_LAST) begin
                limit_q[lim_off] <= req.wdata;
            end
        end
    end

    // Status byte
    always_comb begin
        status_byte = 8'h00;
        status_byte[`STAT_CONV_BUSY] = (conv_q != CONV_IDLE);
        status_byte[`STAT_NV_BUSY]   = nv_busy_q;
        status_byte[`STAT_LOCK]      = lock_q;
    end

    assign bin_off = 4'(req.addr - `ADDR_BIN_FIRST);
    assign lim_off = 3'(req.addr - `ADDR_LIMIT_FIRST);

    // Read decode; unmapped bytes read zero
    always_comb begin
        rd_d = 8'h00;
        if (req.addr >= `ADDR_BIN_FIRST && req.addr <= `ADDR_BIN_LAST) begin
            rd_d = bin_off[0] ? bin_val[bin_off[3:1]][15:8]
                              : bin_val[bin_off[3:1]][7:0];
        end else if (req.addr >= `ADDR_LIMIT_FIRST && req.addr <= `ADDR_LIMIT_LAST) begin
            rd_d = limit_q[lim_off];
        end else begin
            case (req.addr)
                `ADDR_TEMP_WHOLE:  rd_d = temp_q;
                `ADDR_STATUS:      rd_d = status_byte;
                `ADDR_STATUS_RSVD: rd_d = 8'h00;
                `ADDR_ELAPSED_LO:  rd_d = elapsed_q[7:0];
                `ADDR_ELAPSED_MID: rd_d = elapsed_q[15:8];
                `ADDR_ELAPSED_HI:  rd_d = elapsed_q[23:16];
                `ADDR_IDENT_LO:    rd_d = IDENT_VALUE[7:0];
                `ADDR_IDENT_HI:    rd_d = IDENT_VALUE[15:8];
                `ADDR_CYCLE_LO:    rd_d = cycle_q[7:0];
                `ADDR_CYCLE_HI:    rd_d = cycle_q[15:8];
                `ADDR_INTERVAL:    rd_d = {5'h00, interval_q};
                default:           rd_d = 8'h00;
            endcase
        end
    end

    // Read data register, byte loaded on each read and handed to the engine
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_q <= 8'h00;
        end else if (req.rd) begin
            rd_data_q <= rd_d;
        end
    end

    // Checks on freezing, bins, fixed bytes, counters and flags
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_hold_set_start: assert property (cmd.start |=> count_hold_q)
        else $error("hold not set after command");
    a_hold_clr_reset: assert property (cmd.bus_reset && !cmd.start |=> !count_hold_q)
        else $error("hold not cleared by bus reset");
    a_elapsed_frozen: assert property (count_hold_q && $past(count_hold_q)
                                       |-> $stable(elapsed_q))
        else $error("elapsed moved while frozen");
    a_bins_frozen: assert property (count_hold_q && $past(count_hold_q)
                                    |-> $stable({bin_val[7], bin_val[6], bin_val[5], bin_val[4],
                                                 bin_val[3], bin_val[2], bin_val[1], bin_val[0]}))
        else $error("bin credited while frozen");
    a_one_bin_step: assert property (bin_inc != 8'h00 |=>
                                     bin_val[bin_idx_past] == $past(bin_val[bin_idx])
                                     + 16'h0001)
        else $error("bin did not step by one");
    a_ident_fixed: assert property (req.rd && req.addr == `ADDR_IDENT_HI
                                    |=> rd_data_q == IDENT_VALUE[15:8])
        else $error("identity read wrong");
    a_rsvd_zero: assert property (req.rd && req.addr == `ADDR_STATUS_RSVD
                                  |=> rd_data_q == 8'h00)
        else $error("reserved status byte not zero");
    a_cycle_clear: assert property (cmd.clr_cycle |=> cycle_q == 16'h0000)
        else $error("cycle counter not cleared");
    a_cycle_step: assert property (cmd.inc_cycle && !cmd.clr_cycle
                                   |=> cycle_q == $past(cycle_q) + 16'h0001)
        else $error("cycle counter did not step");
    a_conv_busy: assert property (conv_start_q |-> conv_q != CONV_IDLE ##1
                                  status_byte[`STAT_CONV_BUSY])
        else $error("busy flag low during conversion");
    a_busy_clear: assert property (conv_q != CONV_IDLE && done_rise
                                   |=> !status_byte[`STAT_CONV_BUSY])
        else $error("busy flag stuck after conversion");
    a_temp_stored: assert property (conv_q != CONV_IDLE && done_rise
                                    |=> temp_q == $past(ctemp_s2_q))
        else $error("temperature not stored");
    a_interval_wr: assert property (req.wr && req.addr == `ADDR_INTERVAL
                                    |=> interval_q == $past(req.wdata[2:0]))
        else $error("interval write lost");
    a_nv_busy_len: assert property ($rose(nv_busy_q) |-> nv_busy_q [*8])
        else $error("copy busy too short");
    a_nv_busy_end: assert property (nv_busy_q && nv_cnt_q == NV_COPY_CYCLES - 1
                                    |=> !nv_busy_q)
        else $error("copy busy did not end");

    // Bin index one cycle late, for the step check
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bin_idx_past <= 3'd0;
        end else begin
            bin_idx_past <= bin_idx;
        end
    end
endmodule // batt_hist

// ---- core/batt_hist_regs.svh ----
`ifndef BATT_HIST_REGS_SVH
`define BATT_HIST_REGS_SVH

// Register byte addresses
`define ADDR_TEMP_WHOLE   8'h61
`define ADDR_STATUS       8'h62
`define ADDR_STATUS_RSVD  8'h63
`define ADDR_BIN_FIRST    8'h64
`define ADDR_BIN_LAST     8'h73
`define ADDR_ELAPSED_LO   8'h74
`define ADDR_ELAPSED_MID  8'h75
`define ADDR_ELAPSED_HI   8'h76
`define ADDR_IDENT_LO     8'h80
`define ADDR_IDENT_HI     8'h81
`define ADDR_CYCLE_LO     8'h82
`define ADDR_CYCLE_HI     8'h83
`define ADDR_LIMIT_FIRST  8'h84
`define ADDR_LIMIT_LAST   8'h8A
`define ADDR_INTERVAL     8'h8B

// Status field positions
`define STAT_CONV_BUSY    0
`define STAT_NV_BUSY      1
`define STAT_LOCK         2

// Reset values
`define RST_INTERVAL      3'h1
`define RST_TEMP          8'h00
`define RST_LIMIT0        8'hEC
`define RST_LIMIT_STEP    8'h0A
`define IDENT_VALUE       16'h5A3C

// Timing: clock rate, half-minute base, copy duration
`define CLK_HZ            50000000
`define HALF_MINUTE_S     30
`define NV_COPY_MS        10
`define HALF_MIN_CYCLES   (`HALF_MINUTE_S * `CLK_HZ)
`define NV_COPY_CYCLES    ((`NV_COPY_MS * `CLK_HZ) / 1000)
`endif

// ---- core/batt_hist_pkg.sv ----
package batt_hist_pkg;
    // Register access from the serial bus engine
    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } reg_req_t;

    // Command events decoded by the serial bus engine
    typedef struct packed {
        logic start;      // Any command received
        logic bus_reset;  // Bus reset seen
        logic convert;    // On-demand conversion
        logic nv_copy;    // Scratchpad to nonvolatile copy
        logic inc_cycle;  // Charge cycle increment
        logic clr_cycle;  // Charge cycle clear
    } cmd_t;

    typedef enum logic [1:0] {
        CONV_IDLE     = 2'b00,
        CONV_PERIODIC = 2'b01,
        CONV_DEMAND   = 2'b10
    } conv_state_t;
endpackage

// ---- core/bin_accum.sv ----
module bin_accum
    import batt_hist_pkg::*;
(
    input  wire logic        sys_clk,  // System clock
    input  wire logic        nrst,     // Async reset, active low
    input  wire logic        inc,      // Add one interval unit
    output logic      [15:0] count_q   // Accumulated time
);
    // Wrapping accumulator
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            count_q <= 16'h0000;
        end else if (inc) begin
            count_q <= count_q + 16'h0001;
        end
    end
endmodule // bin_accum

// ---- verification/temp_sensor_model.sv ----
module temp_sensor_model (
    input  wire logic       sys_clk,   // Bench clock
    input  wire logic       start,     // Conversion start pulse
    input  wire logic [7:0] temp_set,  // Temperature to report
    input  wire logic [7:0] delay,     // Cycles before the result appears
    output logic            done,      // Result ready level
    output logic      [7:0] temp       // Result bus
);
    timeunit 1ns;
    timeprecision 1ps;

    // One conversion at a time; the result bus only holds around the done rise
    initial begin
        done = 1'b0;
        temp = 8'h00;
        forever begin
            @(posedge sys_clk);
            if (start === 1'b1) begin
                repeat (delay) @(posedge sys_clk);
                temp <= temp_set;
                repeat (3) @(posedge sys_clk);
                done <= 1'b1;
                repeat (6) @(posedge sys_clk);
                done <= 1'b0;
                repeat (2) @(posedge sys_clk);
                temp <= ~temp_set;  // Stale value no longer held
            end
        end
    end
endmodule // temp_sensor_model

// ---- verification/test_batt_hist.sv ----
module test_batt_hist
    import batt_hist_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned HALF_MIN = 20;
    localparam int unsigned NV_COPY  = 16;
    localparam logic [15:0] IDENT    = 16'h3C96;  // Arbitrary value
    localparam logic [7:0]  MULT [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0F, 8'h1E, 8'h3C, 8'h78};
    localparam logic [7:0]  RST_LIM [7] = '{8'hEC, 8'hF6, 8'h00, 8'h0A, 8'h14, 8'h1E, 8'h28};
    localparam logic [7:0]  NEW_LIM [7] = '{8'hD8, 8'hE7, 8'hF6, 8'h00, 8'h19, 8'h37, 8'h55};
    localparam logic [7:0]  TEMPS [10] = '{8'hD8, 8'hEC, 8'hF6, 8'hFF, 8'h00,
                                           8'h0A, 8'h14, 8'h27, 8'h28, 8'h55};
    localparam int          BINS [10]  = '{1, 2, 3, 3, 4, 5, 6, 7, 8, 8};
    localparam cmd_t        C_START = '{start: 1'b1, default: 1'b0};
    localparam cmd_t        C_RESET = '{bus_reset: 1'b1, default: 1'b0};
    localparam cmd_t        C_CONV  = '{convert: 1'b1, default: 1'b0};
    localparam cmd_t        C_NV    = '{nv_copy: 1'b1, default: 1'b0};
    localparam cmd_t        C_INC   = '{inc_cycle: 1'b1, default: 1'b0};
    localparam cmd_t        C_CLR   = '{clr_cycle: 1'b1, default: 1'b0};

    logic        sys_clk;
    logic        nrst;
    reg_req_t    req;
    cmd_t        cmd;
    logic        page_lock;
    logic        conv_done;
    logic [7:0]  conv_temp;
    logic [7:0]  rd_data_q;
    logic        conv_start_q;
    logic        count_hold_q;
    logic [7:0]  temp_set;
    logic [7:0]  delay;
    int          n_errors;
    int          checks;
    logic [15:0] bins_a [8];
    logic [15:0] bins_b [8];
    logic [23:0] mins_a;
    logic [23:0] mins_b;

    batt_hist #(
        .HALF_MIN_CYCLES (HALF_MIN),
        .NV_COPY_CYCLES  (NV_COPY),
        .IDENT_VALUE     (IDENT)
    ) dut_u (
        .sys_clk      (sys_clk),
        .nrst         (nrst),
        .req          (req),
        .cmd          (cmd),
        .page_lock    (page_lock),
        .conv_done    (conv_done),
        .conv_temp    (conv_temp),
        .rd_data_q    (rd_data_q),
        .conv_start_q (conv_start_q),
        .count_hold_q (count_hold_q)
    );

    temp_sensor_model sensor_u (
        .sys_clk  (sys_clk),
        .start    (conv_start_q),
        .temp_set (temp_set),
        .delay    (delay),
        .done     (conv_done),
        .temp     (conv_temp)
    );

    // Free-running 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    task automatic finish_test;
        $display("Checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_span(input logic [23:0] got, input logic [23:0] lo, input logic [23:0] hi);
        checks++;
        if ((got >= lo) !== 1'b1 || (got <= hi) !== 1'b1) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    // Register bus cycles, one cycle request, data one cycle after read
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: v};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 d = rd_data_q;
    endtask

    task automatic pulse(input cmd_t c);
        @(posedge sys_clk);
        cmd <= c;
        @(posedge sys_clk);
        cmd <= '0;
    endtask

    // Freeze or resume counting and confirm the hold output
    task automatic hold(input logic on);
        pulse(on ? C_START : C_RESET);
        #1 chk_byte({7'h00, count_hold_q}, {7'h00, on});
    endtask

    task automatic snap(output logic [15:0] b [8], output logic [23:0] m);
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] up;
        for (int i = 0; i < 8; i++) begin
            rd(8'h64 + 8'(2 * i), lo);
            rd(8'h65 + 8'(2 * i), hi);
            b[i] = {hi, lo};
        end
        rd(8'h74, lo);
        rd(8'h75, hi);
        rd(8'h76, up);
        m = {up, hi, lo};
    endtask

    task automatic t_reset;
        logic [7:0] d;
        snap(bins_a, mins_a);
        for (int i = 0; i < 8; i++) begin
            chk_span(24'(bins_a[i]), 24'h0, 24'h0);
        end
        chk_span(mins_a, 24'h0, 24'h0);
        for (int i = 0; i < 7; i++) begin
            rd(8'h84 + 8'(i), d);
            chk_byte(d, RST_LIM[i]);
        end
        rd(8'h8B, d);
        chk_byte(d & 8'h07, 8'h01);
        rd(8'h62, d);
        chk_byte(d, 8'h00);
        rd(8'h63, d);
        chk_byte(d, 8'h00);
        rd(8'h90, d);
        chk_byte(d, 8'h00);  // Unmapped address
    endtask

    task automatic t_regs;
        logic [7:0] d;
        wr(8'h80, 8'hFF);
        wr(8'h81, 8'hFF);
        rd(8'h80, d);
        chk_byte(d, IDENT[7:0]);
        rd(8'h81, d);
        chk_byte(d, IDENT[15:8]);
        for (int c = 0; c < 8; c++) begin
            wr(8'h8B, 8'(c));
            rd(8'h8B, d);
            chk_byte(d & 8'h07, 8'(c));
        end
    endtask

    // On-demand conversion; returns how many status polls it stayed busy
    task automatic convert(input logic [2:0] code, input logic [7:0] t, output int polls);
        logic [7:0] d;
        @(posedge sys_clk);
        temp_set <= t;
        delay    <= 8'h0A;
        wr(8'h8B, {5'h00, code});
        pulse(C_CONV);
        #1 chk_byte({7'h00, conv_start_q}, 8'h01);
        rd(8'h62, d);
        chk_byte(d & 8'h01, 8'h01);
        polls = 0;
        while (d[0] !== 1'b0 && polls < 100) begin
            rd(8'h62, d);
            polls++;
        end
        chk_byte(d & 8'h01, 8'h00);
        rd(8'h61, d);
        chk_byte(d, t);
    endtask

    task automatic t_convert;
        int p0;
        int p1;
        convert(3'h0, 8'h55, p0);
        convert(3'h7, 8'hE7, p1);
        chk_span(24'(p1), 24'(p0), 24'(p0));
        convert(3'h3, 8'hD8, p1);
        chk_span(24'(p1), 24'(p0), 24'(p0));
    endtask

    task automatic t_status;
        logic [7:0] d;
        pulse(C_NV);
        rd(8'h62, d);
        chk_byte(d & 8'h02, 8'h02);
        repeat (NV_COPY + 4) @(posedge sys_clk);
        rd(8'h62, d);
        chk_byte(d & 8'h02, 8'h00);
        @(posedge sys_clk);
        page_lock <= 1'b1;
        repeat (5) @(posedge sys_clk);
        rd(8'h62, d);
        chk_byte(d & 8'h04, 8'h04);
        @(posedge sys_clk);
        page_lock <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rd(8'h62, d);
        chk_byte(d & 8'h04, 8'h00);
    endtask

    task automatic t_cycle;
        logic [7:0] lo;
        logic [7:0] hi;
        repeat (3) pulse(C_INC);
        rd(8'h82, lo);
        rd(8'h83, hi);
        chk_span(24'({hi, lo}), 24'h3, 24'h3);
        pulse(C_CLR);
        rd(8'h82, lo);
        rd(8'h83, hi);
        chk_span(24'({hi, lo}), 24'h0, 24'h0);
        snap(bins_b, mins_b);
        chk_span(mins_b, 24'h0, 24'h0);
        chk_span(24'(bins_b[3]), 24'h0, 24'h0);
    endtask

    // Let counting run four sample periods at one temperature and judge the deltas
    task automatic run_bin(input logic [2:0] code, input logic [7:0] t, input int bin);
        logic [23:0] e;
        e = 24'(MULT[code]) * 24'h2;
        @(posedge sys_clk);
        temp_set <= t;
        delay    <= 8'h02;
        wr(8'h8B, {5'h00, code});
        snap(bins_a, mins_a);
        hold(1'b0);
        repeat (4 * HALF_MIN * MULT[code]) @(posedge sys_clk);
        hold(1'b1);
        snap(bins_b, mins_b);
        for (int i = 0; i < 8; i++) begin
            if (i == bin - 1) begin
                chk_span(24'(bins_b[i] - bins_a[i]), 24'h3, 24'h5);
            end else begin
                chk_span(24'(bins_b[i] - bins_a[i]), 24'h0, 24'h0);
            end
        end
        chk_span(mins_b - mins_a, e - 24'h1, e + 24'h1);
    endtask

    task automatic t_hist;
        logic [7:0] d;
        for (int c = 0; c < 8; c++) begin
            run_bin(3'(c), 8'h00, 4);
        end
        for (int i = 0; i < 10; i++) begin
            run_bin(3'h0, TEMPS[i], BINS[i]);
        end
        for (int i = 0; i < 7; i++) begin
            wr(8'h84 + 8'(i), NEW_LIM[i]);
            rd(8'h84 + 8'(i), d);
            chk_byte(d, NEW_LIM[i]);
        end
        run_bin(3'h0, 8'h19, 6);
    endtask

    // Main sequence
    initial begin
        sys_clk   = 1'b0;
        nrst      = 1'b0;
        req       = '0;
        cmd       = '0;
        page_lock = 1'b0;
        temp_set  = 8'h00;
        delay     = 8'h02;
        n_errors  = 0;
        checks    = 0;
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        hold(1'b1);
        t_reset();
        t_regs();
        t_convert();
        t_status();
        t_cycle();
        t_hist();
        finish_test();
    end

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end
endmodule // test_batt_hist
